// File: test_vts_regs.sv
// Self-checking bench for the telemetry register bank
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Bench top
module test_vts_regs
  import vts_pkg::*;
;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        arst_n;
  vts_meas_t   meas;
  logic [7:0]  lim_pin;
  logic        lim_valid;
  logic        rd_stb, wr_stb, rvalid, busy;
  logic [7:0]  addr, wdata, rdata;
  logic        alert_out, alert_oe_n, hot_out, hot_oe_n;
  logic [8:0]  exp_q[$];
  logic [8:0]  e;
  logic [31:0] seed = 32'h00000041;
  int          errors = 0;
  int          samples_checked = 0;
  logic [7:0]  lim, tmax, prev_sec, p, val;
  logic [7:0]  ra[9];
  logic [7:0]  ev[9];

  // Clocks, unrelated in phase
  always #25 clk = ~clk;
  always #3 link_clk = ~link_clk;

  vts_regs vts_regs_i (
    .clk(clk), .arst_n(arst_n), .meas_in(meas), .current_limit_program_pin(lim_pin),
    .current_limit_valid(lim_valid), .link_clk(link_clk), .link_rd_stb(rd_stb),
    .link_wr_stb(wr_stb), .link_addr(addr), .link_wdata(wdata), .link_rdata(rdata),
    .link_rvalid(rvalid), .link_busy(busy), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .overtemperature_indicator_out(hot_out),
    .overtemperature_indicator_oe_n(hot_oe_n));

  vts_link_master vts_link_master_i (
    .link_clk(link_clk), .link_rvalid(rvalid), .link_rd_stb(rd_stb),
    .link_wr_stb(wr_stb), .link_addr(addr), .link_wdata(wdata));

  // ==========================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back({1'b1, x});
    vts_link_master_i.xfer(1'b0, a, rnd(), int'(rnd() % 8'h03));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back(9'h000);
    vts_link_master_i.xfer(1'b1, a, d, int'(rnd() % 8'h03));
  endtask

  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Answer monitor takes the oldest note per answer
  always @(posedge link_clk) begin
    if (rvalid === 1'b1) begin
      check({7'h00, busy}, 8'h00);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        if (e[8]) check(rdata, e[7:0]);
      end else begin
        check(8'hff, 8'h00);
      end
    end
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    lim_pin = 8'h00;
    lim_valid = 1'b0;
    meas = '0;
    prev_sec = 8'h00;
    p = 8'h00;
    ra = '{8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset contents, fixed codes, unmapped index
    rd(8'h22, 8'h6a);
    rd(8'h06, 8'hd7);
    rd(8'h21, 8'h00);
    rd(8'h03, 8'h00);
    // Limit captured once; later pin change and writes ignored
    lim = rnd();
    @(posedge clk);
    lim_pin <= lim;
    lim_valid <= 1'b1;
    repeat (2) @(posedge clk);
    lim_pin <= ~lim;
    repeat (2) @(posedge clk);
    wr(8'h21, ~lim);
    rd(8'h21, lim);
    // Writable temperature limit and hot indication at the boundary
    tmax = rnd() | 8'h01;
    wr(8'h22, tmax);
    rd(8'h22, tmax);
    @(posedge clk);
    meas.temp <= tmax;
    repeat (3) @(posedge clk);
    check({7'h00, hot_oe_n}, 8'h00);
    meas.temp <= tmax - 8'h01;
    repeat (3) @(posedge clk);
    check({7'h00, hot_oe_n}, 8'h01);
    // Random telemetry, attention and last-read copy
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      for (int k = 0; k < 8; k++) meas[k*8 +: 8] <= rnd();
      repeat (4) @(posedge clk);
      val = 8'((16'(meas.vout) * 16'(meas.iout)) >> 8);
      ev = '{meas.primary_status, meas.secondary_status, meas.temp_zone, meas.iout,
             meas.vout, meas.temp, val, meas.vin, meas.pin};
      check({7'h00, alert_oe_n}, {7'h00, meas.primary_status === p});
      p = meas.primary_status;
      rd(8'h1c, prev_sec);
      for (int k = 0; k < 9; k++) rd(ra[k], ev[k]);
      rd(8'h1c, meas.secondary_status);
      prev_sec = meas.secondary_status;
      wr(8'h16, ~meas.vout);
      rd(8'h16, meas.vout);
      repeat (2) @(posedge clk);
      check({7'h00, alert_oe_n}, 8'h01);
    end
    // Second reset in mid-run restores the temperature limit default
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({7'h00, alert_oe_n & hot_oe_n}, 8'h01);
    check({6'h00, alert_out, hot_out}, 8'h00);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h22, 8'h6a);
    repeat (20) @(posedge link_clk);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule // test_vts_regs

`default_nettype wire

// File: vts_defs.svh
// Register indices, reset values and fixed codes of the telemetry bank
`ifndef VTS_DEFS_SVH
`define VTS_DEFS_SVH

// ==========================================
// Register indices
`define VTS_IDX_CAPABILITY   8'h06
`define VTS_IDX_PRIM_STATUS  8'h10
`define VTS_IDX_SEC_STATUS   8'h11
`define VTS_IDX_TEMP_ZONE    8'h12
`define VTS_IDX_IOUT         8'h15
`define VTS_IDX_VOUT         8'h16
`define VTS_IDX_REGULATOR_TEMPERATURE      8'h17
`define VTS_IDX_POUT         8'h18
`define VTS_IDX_VIN          8'h1a
`define VTS_IDX_PIN          8'h1b
`define VTS_IDX_PREV_SEC     8'h1c
`define VTS_IDX_CUR_LIMIT    8'h21
`define VTS_IDX_TEMP_LIMIT   8'h22

// ==========================================
// Reset values and fixed contents
`define VTS_RST_ZERO         8'h00
`define VTS_RST_POUT         8'h01
`define VTS_RST_TEMP_LIMIT   8'h6a
`define VTS_CAPABILITY_VAL   8'hd7
`define VTS_UNMAPPED_VAL     8'h00
`define VTS_TEMP_UNSUPPORTED 8'h00

// ==========================================
// Field positions
`define VTS_POUT_HI          15
`define VTS_POUT_LO          8

`endif

// File: vts_link_master.sv
// Link-side request model standing in for the bus master logic
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Request driver
module vts_link_master (
  input  wire logic       link_clk,
  input  wire logic       link_rvalid,
  output var  logic       link_rd_stb,
  output var  logic       link_wr_stb,
  output var  logic [7:0] link_addr,
  output var  logic [7:0] link_wdata
);
  time t_done = 0;

  // Quiet request lines at time zero
  initial begin
    link_rd_stb = 1'b0;
    link_wr_stb = 1'b0;
    link_addr   = 8'h00;
    link_wdata  = 8'h00;
  end

  // One request at a time; gap sets a prompt or slow issue
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap);
    int n;
    if ($time != t_done) @(posedge link_clk);
    repeat (gap) @(posedge link_clk);
    link_rd_stb <= ~wr;
    link_wr_stb <= wr;
    link_addr   <= a;
    link_wdata  <= d;
    @(posedge link_clk);
    link_rd_stb <= 1'b0;
    link_wr_stb <= 1'b0;
    link_addr   <= ~a; // Idle lines never show the last value
    link_wdata  <= ~d;
    n = 0;
    while (link_rvalid !== 1'b1 && n < 40) begin
      @(posedge link_clk);
      n++;
    end
    t_done = $time;
  endtask
endmodule // vts_link_master

`default_nettype wire

// File: vts_pkg.sv
// Types shared by the telemetry register bank
`default_nettype none

package vts_pkg;

  // ==========================================
  // Measurement values from the analog front end
  typedef struct packed {
    logic [7:0] primary_status;
    logic [7:0] secondary_status;
    logic [7:0] temp_zone;
    logic [7:0] iout;
    logic [7:0] vout;
    logic [7:0] temp;
    logic [7:0] vin;
    logic [7:0] pin;
  } vts_meas_t;

  // ==========================================
  // Register request held across the clock crossing
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vts_req_t;

endpackage

`default_nettype wire

// File: vts_regs.sv
// Telemetry and status register bank with link-clock request crossing
//
// Behaviour
// - Primary status at 10h, read after attention
// - Optional secondary status, read-only at 11h
// - Reading 11h copies value into 1Ch
// - Temperature zones read-only at 12h
// - Output current at 15h, FFh equals limit
// - Output voltage at 16h, 8 mV steps
// - Temperature at 17h in degrees, 00h unsupported
// - Output power is upper byte of voltage times current, 18h
// - Input voltage code at 1Ah
// - Input power register at 1Bh
// - Current limit captured at power-up, read-only
// - Temperature limit 22h, default 6Ah, writable
// - Capability bits 2, 1, 0 read one
// - Open-drain attention line pulled low for status
// - Capability bit 7 reads one
`timescale 1ns/10ps
`default_nettype none
`include "vts_defs.svh"

module vts_regs
  import vts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire vts_meas_t  meas_in,
  input  wire logic [7:0] current_limit_program_pin,
  input  wire logic       current_limit_valid,
  input  wire logic       link_clk,
  input  wire logic       link_rd_stb,
  input  wire logic       link_wr_stb,
  input  wire logic [7:0] link_addr,
  input  wire logic [7:0] link_wdata,
  output logic      [7:0] link_rdata,
  output logic            link_rvalid,
  output logic            link_busy,
  output logic            alert_out,
  output logic            alert_oe_n,
  output logic            overtemperature_indicator_out,
  output logic            overtemperature_indicator_oe_n
);

  // ==========================================
  // Link domain
  vts_req_t   req_hold_r;
  logic       req_tgl_r;
  logic       busy_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       ack_s3_r;
  logic       ack_evt;
  logic [7:0] link_rdata_r;
  logic       link_rvalid_r;

  // ==========================================
  // Core domain
  logic       req_s1_r;
  logic       req_s2_r;
  logic       req_s3_r;
  logic       req_evt;
  logic       ack_tgl_r;
  logic [7:0] resp_data_r;
  logic [7:0] rd_mux;
  logic       rd_evt;
  logic       wr_evt;
  logic [7:0] prim_r;
  logic [7:0] sec_r;
  logic [7:0] zone_r;
  logic [7:0] iout_r;
  logic [7:0] vout_r;
  logic [7:0] temp_r;
  logic [7:0] pout_r;
  logic [7:0] vin_r;
  logic [7:0] pin_r;
  logic [7:0] prev_sec_r;
  logic [7:0] limit_r;
  logic       limit_done_r;
  logic [7:0] tmax_r;
  logic       alert_pend_r;
  logic       alert_oe_n_r;
  logic       hot_oe_n_r;
  logic [15:0] pout_prod;

  // ==========================================
  // Link side: accept one request at a time
  assign ack_evt = ack_s2_r ^ ack_s3_r;

  // Request capture and toggle towards the core
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_hold_r <= '0;
      req_tgl_r  <= 1'b0;
    end else if ((link_rd_stb || link_wr_stb) && !busy_r) begin
      req_hold_r <= '{wr: link_wr_stb, addr: link_addr, wdata: link_wdata};
      req_tgl_r  <= ~req_tgl_r;
    end
  end

  // Busy from acceptance until the answer returns
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (ack_evt) begin
      busy_r <= 1'b0;
    end else if (link_rd_stb || link_wr_stb) begin
      busy_r <= 1'b1;
    end
  end

  // Answer toggle synchroniser
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  // Read data, held stable by the handshake on the core side
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_rdata_r  <= `VTS_RST_ZERO;
      link_rvalid_r <= 1'b0;
    end else begin
      link_rvalid_r <= ack_evt;
      if (ack_evt) begin
        link_rdata_r <= resp_data_r;
      end
    end
  end

  assign link_rdata  = link_rdata_r;
  assign link_rvalid = link_rvalid_r;
  assign link_busy   = busy_r;

  // ==========================================
  // Core side: request synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign req_evt = req_s2_r ^ req_s3_r;
  assign rd_evt  = req_evt && !req_hold_r.wr;
  assign wr_evt  = req_evt && req_hold_r.wr;

  // ==========================================
  // Telemetry sampling, never blocked by bus traffic
  assign pout_prod = 16'(vout_r) * 16'(iout_r); // Widened so no product bit is lost

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prim_r <= `VTS_RST_ZERO;
      sec_r  <= `VTS_RST_ZERO;
      zone_r <= `VTS_RST_ZERO;
      iout_r <= `VTS_RST_ZERO;
      vout_r <= `VTS_RST_ZERO;
      temp_r <= `VTS_RST_ZERO;
      pout_r <= `VTS_RST_POUT;
      vin_r  <= `VTS_RST_ZERO;
      pin_r  <= `VTS_RST_ZERO;
    end else begin
      prim_r <= meas_in.primary_status;
      sec_r  <= meas_in.secondary_status;
      zone_r <= meas_in.temp_zone;
      iout_r <= meas_in.iout;
      vout_r <= meas_in.vout;
      temp_r <= meas_in.temp;
      pout_r <= pout_prod[`VTS_POUT_HI:`VTS_POUT_LO];
      vin_r  <= meas_in.vin;
      pin_r  <= meas_in.pin;
    end
  end

  // Current limit latched once after power-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      limit_r      <= `VTS_RST_ZERO;
      limit_done_r <= 1'b0;
    end else if (!limit_done_r && current_limit_valid) begin
      limit_r      <= current_limit_program_pin;
      limit_done_r <= 1'b1;
    end
  end

  // Only the temperature limit accepts writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmax_r <= `VTS_RST_TEMP_LIMIT;
    end else if (wr_evt && req_hold_r.addr == `VTS_IDX_TEMP_LIMIT) begin
      tmax_r <= req_hold_r.wdata;
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (req_hold_r.addr)
      `VTS_IDX_CAPABILITY:  rd_mux = `VTS_CAPABILITY_VAL;
      `VTS_IDX_PRIM_STATUS: rd_mux = prim_r;
      `VTS_IDX_SEC_STATUS:  rd_mux = sec_r;
      `VTS_IDX_TEMP_ZONE:   rd_mux = zone_r;
      `VTS_IDX_IOUT:        rd_mux = iout_r;
      `VTS_IDX_VOUT:        rd_mux = vout_r;
      `VTS_IDX_REGULATOR_TEMPERATURE:     rd_mux = temp_r;
      `VTS_IDX_POUT:        rd_mux = pout_r;
      `VTS_IDX_VIN:         rd_mux = vin_r;
      `VTS_IDX_PIN:         rd_mux = pin_r;
      `VTS_IDX_PREV_SEC:    rd_mux = prev_sec_r;
      `VTS_IDX_CUR_LIMIT:   rd_mux = limit_r;
      `VTS_IDX_TEMP_LIMIT:  rd_mux = tmax_r;
      default:              rd_mux = `VTS_UNMAPPED_VAL;
    endcase
  end

  // Answer data and toggle back to the link
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_data_r <= `VTS_RST_ZERO;
      ack_tgl_r   <= 1'b0;
    end else if (req_evt) begin
      ack_tgl_r <= ~ack_tgl_r;
      if (!req_hold_r.wr) begin
        resp_data_r <= rd_mux;
      end
    end
  end

  // Copy of the secondary status as it was read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_sec_r <= `VTS_RST_ZERO;
    end else if (rd_evt && req_hold_r.addr == `VTS_IDX_SEC_STATUS) begin
      prev_sec_r <= sec_r;
    end
  end

  // ==========================================
  // Attention: status change sets, status read clears, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_pend_r <= 1'b0;
    end else if (meas_in.primary_status != prim_r) begin
      alert_pend_r <= 1'b1;
    end else if (rd_evt && req_hold_r.addr == `VTS_IDX_PRIM_STATUS) begin
      alert_pend_r <= 1'b0;
    end
  end

  // Open-drain pins: enable low pulls the wire low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_oe_n_r <= 1'b1;
      hot_oe_n_r   <= 1'b1;
    end else begin
      alert_oe_n_r <= ~alert_pend_r;
      hot_oe_n_r   <= ~((temp_r != `VTS_TEMP_UNSUPPORTED) && (temp_r >= tmax_r));
    end
  end

  assign alert_out                      = 1'b0;
  assign alert_oe_n                     = alert_oe_n_r;
  assign overtemperature_indicator_out  = 1'b0;
  assign overtemperature_indicator_oe_n = hot_oe_n_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_read_of(logic [7:0] idx);
    rd_evt && req_hold_r.addr == idx;
  endsequence

  sequence s_write_of(logic [7:0] idx);
    wr_evt && req_hold_r.addr == idx;
  endsequence

  a_prim_read_data: assert property (s_read_of(`VTS_IDX_PRIM_STATUS) |=>
    resp_data_r == $past(prim_r))
    else $error("primary status read returned wrong data");

  a_sec_read_data: assert property (s_read_of(`VTS_IDX_SEC_STATUS) |=>
    resp_data_r == $past(sec_r))
    else $error("secondary status read returned wrong data");

  a_prev_sec_copy: assert property (s_read_of(`VTS_IDX_SEC_STATUS) |=>
    prev_sec_r == resp_data_r)
    else $error("last-read copy differs from value read");

  // Tracking checks start only from an edge that sampled reset released,
  // so reset contents never meet live inputs
  a_zone_track: assert property (arst_n |=> zone_r == $past(meas_in.temp_zone))
    else $error("temperature zone not tracking input");

  a_iout_track: assert property (arst_n |=> iout_r == $past(meas_in.iout))
    else $error("output current not tracking input");

  a_vout_track: assert property (arst_n |=> vout_r == $past(meas_in.vout))
    else $error("output voltage not tracking input");

  a_temp_track: assert property (arst_n |=> temp_r == $past(meas_in.temp))
    else $error("temperature not tracking input");

  a_pout_product: assert property (arst_n |=> ##1
    pout_r == 8'((16'($past(meas_in.vout, 2)) * 16'($past(meas_in.iout, 2))) >> `VTS_POUT_LO))
    else $error("output power is not voltage times current");

  a_vin_track: assert property (arst_n |=> vin_r == $past(meas_in.vin))
    else $error("input voltage not tracking input");

  a_pin_track: assert property (arst_n |=> pin_r == $past(meas_in.pin))
    else $error("input power not tracking input");

  a_limit_capture: assert property (arst_n && !limit_done_r && current_limit_valid
    |=> limit_r == $past(current_limit_program_pin) && limit_done_r)
    else $error("current limit not captured from pin");

  a_limit_frozen: assert property (limit_done_r |=> $stable(limit_r))
    else $error("current limit changed after capture");

  a_tmax_write: assert property (s_write_of(`VTS_IDX_TEMP_LIMIT) |=>
    tmax_r == $past(req_hold_r.wdata))
    else $error("temperature limit write not taken");

  a_cap_read: assert property (s_read_of(`VTS_IDX_CAPABILITY) |=>
    resp_data_r == `VTS_CAPABILITY_VAL)
    else $error("capability read wrong");

  a_alert_drive: assert property (arst_n && (meas_in.primary_status != prim_r) |=>
    ##1 !alert_oe_n_r)
    else $error("attention not pulled after status change");

  a_alert_release: assert property (s_read_of(`VTS_IDX_PRIM_STATUS) ##0
    (meas_in.primary_status == prim_r) |=> ##1 alert_oe_n_r)
    else $error("attention still pulled after status read");

  a_hot_drive: assert property (arst_n && (meas_in.temp != `VTS_TEMP_UNSUPPORTED)
    && (meas_in.temp >= tmax_r) && !wr_evt |=> ##1 !hot_oe_n_r)
    else $error("hot indication not asserted at temperature limit");

  a_cap_fmt_bit: assert property (s_read_of(`VTS_IDX_CAPABILITY) |=>
    resp_data_r[7])
    else $error("current format bit not one");

  a_ro_ignored: assert property (wr_evt && req_hold_r.addr != `VTS_IDX_TEMP_LIMIT
    |=> $stable(tmax_r))
    else $error("write to read-only register changed state");

  // Link-domain checks carry their own clock and reset
  a_link_answer: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(busy_r) |-> ##[3:40] link_rvalid_r)
    else $error("link request not answered in time");

  a_answer_busy: assert property (@(posedge link_clk) disable iff (!arst_n)
    link_rvalid_r |-> !busy_r && $past(busy_r))
    else $error("busy not ended by the answer");

  a_rvalid_pulse: assert property (@(posedge link_clk) disable iff (!arst_n)
    link_rvalid_r |=> !link_rvalid_r)
    else $error("answer strobe longer than one cycle");

endmodule // vts_regs

`default_nettype wire
